// ==== inc/aic_link_if.sv ====
// Purpose: Carries sampled link bits from the bus clock domain to the core.
// Assumes: rx_bit is stable whenever rx_tog is stable.
// Notes: The core synchronises rx_tog before looking at rx_bit.
`timescale 1ns/1ps

interface aic_link_if;
	logic rx_bit;
	logic rx_tog;
	modport link (output rx_bit, output rx_tog);
	modport core (input rx_bit, input rx_tog);
endinterface

// ==== inc/aic_pkg.sv ====
// Purpose: Shared constants, state codes and address decode for the converter I2C front end.
// Assumes: One package imported whole by every design file of the block.
// Notes: Figures below are fixed; only the conversion length is overridable at the top.

package aic_pkg;

	// ****************************************
	// Framing and result layout
	// ****************************************
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [4:0] RESULT_BITS = 5'h18;
	localparam int RESULT_MSB = 23;
	localparam logic [5:0] RESULT_PAD = 6'h00;
	localparam logic signed [19:0] POS_CLAMP = 20'sh10000;
	localparam logic signed [19:0] NEG_CLAMP = 20'shEFFFF;
	localparam logic [23:0] RESULT_RESET = 24'h000000;

	// ****************************************
	// Configuration byte layout
	// ****************************************
	localparam logic [2:0] CFG_LOAD = 3'h5;
	localparam logic [2:0] CFG_KEEP_A = 3'h0;
	localparam logic [2:0] CFG_KEEP_B = 3'h4;
	localparam int SEL_SGL_POS = 4;
	localparam int SEL_SWAP_POS = 3;
	localparam int SEL_A0_POS = 0;
	localparam logic [4:0] DEFAULT_SEL = 5'h00;

	// One-hot analog input routing codes.
	localparam logic [4:0] INPUT_CH0 = 5'h01;
	localparam logic [4:0] INPUT_CH1 = 5'h02;
	localparam logic [4:0] INPUT_CH2 = 5'h04;
	localparam logic [4:0] INPUT_CH3 = 5'h08;
	localparam logic [4:0] COMMON_RETURN = 5'h10;

	// ****************************************
	// Addressing and timing
	// ****************************************
	localparam logic [6:0] GLOBAL_ADDR = 7'h77;
	localparam logic [1:0] PIN_LOW = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_FLOAT = 2'h2;
	localparam logic [15:0] CONV_CYCLES_DEFAULT = 16'h2710;

	typedef enum logic [3:0] {
		AIC_IDLE = 4'b0001,
		AIC_ADDR = 4'b0010,
		AIC_WDATA = 4'b0100,
		AIC_RDATA = 4'b1000
	} aic_state_t;

	// Strap decode; a pair holding an unused pin code decodes as both pins floating.
	function automatic logic [6:0] aic_strap_addr(input logic [1:0] p1, input logic [1:0] p0);
		logic [6:0] a;
		a = 7'h24;
		case ({p1, p0})
			{PIN_LOW, PIN_LOW}: a = 7'h14;
			{PIN_LOW, PIN_HIGH}: a = 7'h16;
			{PIN_LOW, PIN_FLOAT}: a = 7'h15;
			{PIN_HIGH, PIN_LOW}: a = 7'h26;
			{PIN_HIGH, PIN_HIGH}: a = 7'h34;
			{PIN_HIGH, PIN_FLOAT}: a = 7'h27;
			{PIN_FLOAT, PIN_LOW}: a = 7'h17;
			{PIN_FLOAT, PIN_HIGH}: a = 7'h25;
			default: a = 7'h24;
		endcase
		return a;
	endfunction

endpackage

// ==== rtl/aic_i2c_adc_core.sv ====
// Purpose: I2C slave front end of a converter: address, refuse while busy, result out, channel in.
// Assumes: sda_i and scl_i are the resolved bus levels; straps are static after reset.
// Notes: Bits are sampled on the bus clock; all decisions are made on the system clock.
`timescale 1ns/1ps

module aic_i2c_adc_core #(
	parameter logic [15:0] CONV_CYCLES = aic_pkg::CONV_CYCLES_DEFAULT
) (
	// System clock and reset.
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// I2C bus pins.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// Address straps, three-level each.
	input wire logic [1:0] addr_pin1_i,
	input wire logic [1:0] addr_pin0_i,
	// Converter side.
	input wire logic signed [19:0] conv_sample_i,
	output logic conv_busy_o,
	output logic conv_start_o,
	output logic single_ended_sel_o,
	output logic [4:0] in_pos_o,
	output logic [4:0] in_neg_o
);
	import aic_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;
	logic tog_s1, tog_s2, tog_d;
	logic [1:0] p1_s1, p1_s2, p0_s1, p0_s2;
	logic [6:0] my_addr;
	logic start_ev, stop_ev, rise_ev, fall_ev;
	logic ack_rise, data_rise;
	aic_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] rx_sr;
	logic is_global, addr_hit, addr_ack;
	logic [23:0] tx_sr;
	logic [4:0] sent_cnt;
	logic read_done;
	logic read_active, write_done;
	logic cfg_first;
	logic [4:0] pending_sel, active_sel;
	logic busy;
	logic [15:0] conv_cnt;
	logic [23:0] result;
	logic [23:0] fmt_code;
	logic conv_go;
	logic sda_oe_n;

	aic_link_if lnk ();

	// ****************************************
	// Link sampler and result formatter
	// ****************************************
	aic_link_rx u_link (
		.scl_i(scl_i),
		.sda_i(sda_i),
		.lnk(lnk)
	);

	aic_result_fmt u_fmt (
		.sample_i(conv_sample_i),
		.code_o(fmt_code)
	);

	// ****************************************
	// Synchronisers
	// ****************************************

	// Two flops per asynchronous input; nothing reads the first stage but the second.
	always_ff @(posedge sys_clk_i) begin
		scl_s1 <= scl_i;
		scl_s2 <= scl_s1;
		sda_s1 <= sda_i;
		sda_s2 <= sda_s1;
		tog_s1 <= lnk.rx_tog;
		tog_s2 <= tog_s1;
		p1_s1 <= addr_pin1_i;
		p1_s2 <= p1_s1;
		p0_s1 <= addr_pin0_i;
		p0_s2 <= p0_s1;
	end

	// Delayed copies for edge detection; the toggle copy is aligned in reset.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			tog_d <= tog_s2;
		end else begin
			scl_d <= scl_s2;
			sda_d <= sda_s2;
			tog_d <= tog_s2;
		end
	end

	// Straps are caught while reset is held, so a wiggling pin cannot move the address.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			my_addr <= aic_strap_addr(p1_s2, p0_s2);
		end
	end

	// ****************************************
	// Bus events
	// ****************************************

	// Start and stop are data edges while the clock stays high.
	assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign rise_ev = tog_s2 ^ tog_d;
	assign fall_ev = scl_d & ~scl_s2;
	assign ack_rise = rise_ev & (bit_cnt == ACK_SLOT);
	assign data_rise = rise_ev & (bit_cnt != ACK_SLOT);

	// Address check; a global read is refused, and nothing is taken while busy.
	assign is_global = (rx_sr[7:1] == GLOBAL_ADDR);
	assign addr_hit = (rx_sr[7:1] == my_addr) | is_global;
	assign addr_ack = addr_hit & ~busy & ~(is_global & rx_sr[0]);

	// The third byte's acknowledge slot closes a full read.
	assign read_done = ack_rise & (state == AIC_RDATA) & (sent_cnt == RESULT_BITS);

	// A conversion begins on a full read, or on stop after an accepted access.
	assign conv_go = ~busy & (read_done | (stop_ev & (read_active | write_done)));

	// ****************************************
	// Framing
	// ****************************************

	// Counts bits within each unit and walks address, write and read phases.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state <= AIC_IDLE;
			bit_cnt <= 4'h0;
			rx_sr <= 8'h00;
		end else if (start_ev) begin
			state <= AIC_ADDR;
			bit_cnt <= 4'h0;
		end else if (stop_ev) begin
			state <= AIC_IDLE;
			bit_cnt <= 4'h0;
		end else if (data_rise && state != AIC_IDLE) begin
			rx_sr <= {rx_sr[6:0], lnk.rx_bit};
			bit_cnt <= bit_cnt + 4'h1;
		end else if (ack_rise) begin
			bit_cnt <= 4'h0;
			case (state)
				AIC_ADDR: begin
					if (addr_ack) begin
						state <= rx_sr[0] ? AIC_RDATA : AIC_WDATA;
					end else begin
						state <= AIC_IDLE;
					end
				end
				AIC_WDATA: begin
					state <= AIC_WDATA;
				end
				AIC_RDATA: begin
					// A master NAK or the last byte ends the output phase.
					if (lnk.rx_bit || sent_cnt == RESULT_BITS) begin
						state <= AIC_IDLE;
					end
				end
				default: begin
					state <= AIC_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Data line drive
	// ****************************************

	// Changes only after a falling clock edge; released at start and stop.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sda_oe_n <= 1'b1;
		end else if (start_ev || stop_ev) begin
			sda_oe_n <= 1'b1;
		end else if (fall_ev) begin
			case (state)
				AIC_ADDR: begin
					sda_oe_n <= ~((bit_cnt == ACK_SLOT) & addr_ack);
				end
				AIC_WDATA: begin
					sda_oe_n <= ~(bit_cnt == ACK_SLOT);
				end
				AIC_RDATA: begin
					// Release in the ninth clock so the master can answer.
					sda_oe_n <= (bit_cnt == ACK_SLOT) | tx_sr[RESULT_MSB];
				end
				default: begin
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// The pin is open drain, so only a low level is ever driven.
	always_ff @(posedge sys_clk_i) begin
		sda_o <= 1'b0;
	end

	// ****************************************
	// Result output path
	// ****************************************

	// The word is frozen at address acknowledge, so a finishing conversion cannot tear it.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_sr <= RESULT_RESET;
			sent_cnt <= 5'h00;
		end else if (ack_rise && state == AIC_ADDR) begin
			tx_sr <= result;
			sent_cnt <= 5'h00;
		end else if (data_rise && state == AIC_RDATA) begin
			tx_sr <= {tx_sr[22:0], 1'b0};
			sent_cnt <= sent_cnt + 5'h01;
		end
	end

	// ****************************************
	// Session flags
	// ****************************************

	// Remembers an accepted read or write until its conversion is launched.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			read_active <= 1'b0;
			write_done <= 1'b0;
		end else if (conv_go) begin
			read_active <= 1'b0;
			write_done <= 1'b0;
		end else if (ack_rise && state == AIC_ADDR && addr_ack) begin
			if (rx_sr[0]) begin
				read_active <= 1'b1;
			end else begin
				write_done <= 1'b1;
			end
		end
	end

	// ****************************************
	// Channel configuration
	// ****************************************

	// Only the first byte after the address counts; later bytes are acknowledged and dropped.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pending_sel <= DEFAULT_SEL;
			cfg_first <= 1'b0;
		end else if (ack_rise && state == AIC_ADDR) begin
			cfg_first <= 1'b1;
		end else if (ack_rise && state == AIC_WDATA) begin
			cfg_first <= 1'b0;
			// Headers 000, 100 and the avoided patterns all leave the channel alone.
			if (cfg_first && rx_sr[7:5] == CFG_LOAD) begin
				pending_sel <= rx_sr[4:0];
			end
		end
	end

	// ****************************************
	// Conversion sequencing
	// ****************************************

	// The first conversion runs straight out of reset on the default pair.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			busy <= 1'b1;
			conv_cnt <= CONV_CYCLES;
			active_sel <= DEFAULT_SEL;
			result <= RESULT_RESET;
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= conv_go;
			if (conv_go) begin
				busy <= 1'b1;
				conv_cnt <= CONV_CYCLES;
				active_sel <= pending_sel;
			end else if (busy) begin
				if (conv_cnt <= 16'h0001) begin
					busy <= 1'b0;
					result <= fmt_code;
				end else begin
					conv_cnt <= conv_cnt - 16'h0001;
				end
			end
		end
	end

	// ****************************************
	// Input routing
	// ****************************************

	// Select bits two and one are ignored; swap and bit zero pick channels, and the single bit puts the negative input on the common return.
	function automatic logic [9:0] route(input logic [4:0] sel);
		logic [4:0] lower, upper, pos, neg;
		lower = sel[SEL_A0_POS] ? INPUT_CH2 : INPUT_CH0;
		upper = sel[SEL_A0_POS] ? INPUT_CH3 : INPUT_CH1;
		pos = sel[SEL_SWAP_POS] ? upper : lower;
		neg = sel[SEL_SWAP_POS] ? lower : upper;
		if (sel[SEL_SGL_POS]) begin
			case ({sel[SEL_SWAP_POS], sel[SEL_A0_POS]})
				2'h0: pos = INPUT_CH0;
				2'h2: pos = INPUT_CH1;
				2'h1: pos = INPUT_CH2;
				default: pos = INPUT_CH3;
			endcase
			neg = COMMON_RETURN;
		end
		return {pos, neg};
	endfunction

	// Registered so the analog switches see clean levels.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			in_pos_o <= INPUT_CH0;
			in_neg_o <= INPUT_CH1;
			single_ended_sel_o <= 1'b0;
		end else begin
			{in_pos_o, in_neg_o} <= route(active_sel);
			single_ended_sel_o <= active_sel[SEL_SGL_POS];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sda_oe_n_o = sda_oe_n;
	assign conv_busy_o = busy;

endmodule

// ==== rtl/aic_link_rx.sv ====
// Purpose: Samples the data line on each rising bus clock edge.
// Assumes: The master changes data only while the bus clock is low.
// Notes: Power-up values stand in for a reset, since this clock may never run.
`timescale 1ns/1ps

module aic_link_rx (
	// Link side.
	input wire logic scl_i,
	input wire logic sda_i,
	// Core side.
	aic_link_if.link lnk
);
	import aic_pkg::*;

	logic bit_q = 1'b1;
	logic tog_q = 1'b0;

	// Each rising edge captures one bit and flips the event toggle.
	always_ff @(posedge scl_i) begin
		bit_q <= sda_i;
		tog_q <= ~tog_q;
	end

	assign lnk.rx_bit = bit_q;
	assign lnk.rx_tog = tog_q;
endmodule

// ==== rtl/aic_result_fmt.sv ====
// Purpose: Turns a raw signed sample into the 24-bit result word.
// Assumes: The sample is in result LSB units, full scale at 65536.
// Notes: Purely combinational; the core registers the word at conversion end.
`timescale 1ns/1ps

module aic_result_fmt (
	// Raw sample in.
	input wire logic signed [19:0] sample_i,
	// Formatted word out.
	output logic [23:0] code_o
);
	import aic_pkg::*;

	logic signed [19:0] clamped;

	// Clamp first, so that sign and MSB fall out as the range code.
	always_comb begin
		clamped = sample_i;
		if (sample_i > POS_CLAMP) begin
			clamped = POS_CLAMP;
		end else if (sample_i < NEG_CLAMP) begin
			clamped = NEG_CLAMP;
		end
		code_o = {~clamped[19], clamped[16:0], RESULT_PAD};
	end
endmodule

// ==== test/aic_bus_master.sv ====
// Purpose: Behavioural bus master driving clock and data.
// Assumes: Data line is resolved by the bench with a pull-up.
// Notes: Half period of twelve system cycles stays well above the sampler's sync latency.
`timescale 1ns/1ps

module aic_bus_master (
	// Bus lines.
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	// ****************************************
	// Bus tasks
	// ****************************************
	localparam real T = 120.0;

	// Both lines idle high; the clock stands still between frames.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Start or repeated start; the small delay breaks phase with the system clock.
	task automatic start();
		#3.3;
		sda_o = 1'b1;
		#T;
		scl_o = 1'b1;
		#T;
		sda_o = 1'b0;
		#T;
		scl_o = 1'b0;
	endtask

	// Data changes only while the clock is low; sampled at the end of the high phase.
	task automatic clk_bit(input logic b, output logic r);
		sda_o = b;
		#T;
		scl_o = 1'b1;
		#T;
		r = sda_i;
		scl_o = 1'b0;
	endtask

	// Eight bits then the acknowledge slot; a writer passes last as one to release.
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(last, ack);
	endtask

	// Aborts are only issued straight after an acknowledge slot.
	task automatic stop();
		sda_o = 1'b0;
		#T;
		scl_o = 1'b1;
		#T;
		sda_o = 1'b1;
		#T;
	endtask
endmodule

// ==== test/aic_chk.sv ====
// Purpose: Port-level checks for the converter I2C front end.
// Assumes: Bound to the core; reset is synchronous and active high.
// Notes: Conversion length is handed on from the bound instance.
`timescale 1ns/1ps

module aic_chk #(
	parameter logic [15:0] CONV_CYCLES = 16'h2710
) (
	// Clock, reset and bus.
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_oe_n_o,
	// Converter side.
	input wire logic conv_busy_o,
	input wire logic conv_start_o,
	input wire logic single_ended_sel_o,
	input wire logic [4:0] in_pos_o,
	input wire logic [4:0] in_neg_o
);
	// ****************************************
	// Helper logic and properties
	// ****************************************
	logic [16:0] busy_cnt;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Counts busy cycles, so the conversion length is checked without long repetitions.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || !conv_busy_o) begin
			busy_cnt <= 17'h00000;
		end else begin
			busy_cnt <= busy_cnt + 17'h00001;
		end
	end

	property p_busy_quiet; conv_busy_o && $past(conv_busy_o, 3) |-> sda_oe_n_o; endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("data line pulled while converting");
	property p_pull_low; $fell(sda_oe_n_o) |-> !scl_i; endproperty
	a_pull_low: assert property (p_pull_low)
		else $error("data line pulled while clock high");
	// Busy and the launch pulse are set on the same edge, so both rise together.
	property p_start_pulse; $rose(conv_busy_o) |-> conv_start_o; endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("no start pulse after busy rose");
	property p_busy_len;
		$fell(conv_busy_o) |-> busy_cnt + 17'h00003 >= {1'b0, CONV_CYCLES}
			&& busy_cnt <= {1'b0, CONV_CYCLES} + 17'h00003;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("conversion length wrong");
	property p_reset_vals;
		$fell(sys_rst_i) |-> sda_oe_n_o && conv_busy_o && !single_ended_sel_o
			&& in_pos_o == 5'h01 && in_neg_o == 5'h02;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("wrong state at reset release");
	property p_onehot; $onehot(in_pos_o) && $onehot(in_neg_o) && in_pos_o != in_neg_o; endproperty
	a_onehot: assert property (p_onehot)
		else $error("input routing not one-hot");
	property p_sgl_com;
		$stable(single_ended_sel_o) |-> (in_neg_o == 5'h10) == single_ended_sel_o;
	endproperty
	a_sgl_com: assert property (p_sgl_com)
		else $error("negative input disagrees with mode");
	property p_route_hold; $changed(in_pos_o) |-> conv_start_o || $past(conv_start_o); endproperty
	a_route_hold: assert property (p_route_hold)
		else $error("routing changed outside a launch");

	c_start: cover property (conv_start_o);
	c_ack: cover property ($fell(sda_oe_n_o));
	c_single: cover property (single_ended_sel_o);
endmodule

bind aic_i2c_adc_core aic_chk #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.sys_clk_i, .sys_rst_i,
	.scl_i, .sda_oe_n_o, .conv_busy_o, .conv_start_o, .single_ended_sel_o, .in_pos_o, .in_neg_o);

// ==== test/test_adc_i2c_slave_channel_ctrl.sv ====
// Purpose: Self-checking bench for the converter I2C front end.
// Assumes: Conversion shortened to 400 system cycles.
// Notes: Samples mix fixed corner values with xorshift draws.
`timescale 1ns/1ps

module test_adc_i2c_slave_channel_ctrl;
	import aic_pkg::*;
	// ****************************************
	// Signals, design and partner
	// ****************************************
	localparam logic [15:0] CONV = 16'h0190;
	logic sys_clk, sys_rst, scl, m_sda, sda_w, sda_drv, sda_oe_n, busy, cstart, single_ended_sel;
	logic [1:0] pin1 = 2'h0;
	logic [1:0] pin0 = 2'h0;
	logic signed [19:0] sample = 20'sh00000;
	logic [4:0] pos, neg;
	logic [31:0] seed = 32'hE0F2;
	int num_errors = 0;
	int samples_checked = 0;
	logic [6:0] addr_tab [9] = '{7'h14, 7'h16, 7'h15, 7'h26, 7'h34, 7'h27, 7'h17, 7'h25, 7'h24};
	logic signed [19:0] corner [8] = '{20'sh10000, 20'sh0FFFF, 20'sh00000, 20'shFFFFF,
		20'shF0000, 20'shEFFFF, 20'sh10001, 20'shEEEEE};

	// Open-drain wire: either party may pull low, the pull-up wins otherwise.
	assign sda_w = (sda_oe_n ? 1'b1 : sda_drv) & m_sda;

	aic_i2c_adc_core #(.CONV_CYCLES(CONV)) dut_u (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n), .addr_pin1_i(pin1),
		.addr_pin0_i(pin0), .conv_sample_i(sample), .conv_busy_o(busy), .conv_start_o(cstart),
		.single_ended_sel_o(single_ended_sel), .in_pos_o(pos), .in_neg_o(neg));
	aic_bus_master mst (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Expectations and helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Clamp to the end codes, then sign flag, 17 result bits and six zeros.
	function automatic logic [23:0] exp_word(input logic signed [19:0] s);
		logic signed [19:0] c;
		c = (s > 20'sh10000) ? 20'sh10000 : ((s < 20'shEFFFF) ? 20'shEFFFF : s);
		return {~c[19], c[16:0], 6'h00};
	endfunction

	// Selection {single, swap, low bit} to {single, positive, negative} routing.
	function automatic logic [10:0] exp_route(input logic [2:0] s);
		logic [1:0] p;
		p = {s[0], s[1]};
		return {s[2], 5'h01 << p, s[2] ? 5'h10 : 5'h01 << (p ^ 2'h1)};
	endfunction

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 2000 && busy !== 1'b0; n++) tick(1);
		chk({23'h0, busy}, 24'h0);
	endtask

	task automatic wb(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic a;
		mst.xbyte(d, 1'b1, q, a);
		chk({23'h0, a}, {23'h0, e});
	endtask

	task automatic do_reset(input logic [1:0] a, input logic [1:0] b);
		tick(1);
		sys_rst = 1'b1;
		pin1 = a;
		pin0 = b;
		tick(4);
		chk({11'h0, sda_oe_n, busy, single_ended_sel, pos, neg}, {11'h0, 3'b110, 5'h01, 5'h02});
		sys_rst = 1'b0;
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Bound on the whole run, which needs well under half a millisecond.
	// Kept below a millisecond so that a hang still ends in reasonable time.
	initial begin
		#800000;
		num_errors++;
		results();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [7:0] q, cfg;
		logic a;
		logic [2:0] cur, hdr;
		logic [23:0] rd, ew;
		sys_rst = 1'b1;
		// Every strap pair: a foreign address, then an accepted write; busy refusal on the first pair only.
		for (int k = 0; k < 9; k++) begin
			do_reset(2'(k / 3), 2'(k % 3));
			if (k == 0) begin
				mst.start();
				wb({addr_tab[0], 1'b0}, 1'b1);
			end
			wait_idle();
			mst.start();
			wb({addr_tab[k] ^ 7'h01, 1'b0}, 1'b1);
			mst.start();
			wb({addr_tab[k], 1'b0}, 1'b0);
			mst.stop();
			tick(8);
			chk({23'h0, busy}, 24'h1);
		end
		$display("Address tests done");
		// Global read is refused, global write loads single-ended channel 3.
		wait_idle();
		mst.start();
		wb(8'hEF, 1'b1);
		mst.start();
		wb(8'hEE, 1'b0);
		wb(8'hB9, 1'b0);
		mst.stop();
		tick(8);
		chk({13'h0, single_ended_sel, pos, neg}, {13'h0, 1'b1, 5'h08, 5'h10});
		cur = 3'h7;
		$display("Global address tests done");
		// Write a selection, repeated start, read the result; last pass aborts after a byte.
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			tick(1);
			sample = (i < 8) ? corner[i] : seed[19:0];
			hdr = (i < 8 || i % 3 == 0) ? 3'h5 : ((i % 3 == 1) ? 3'h0 : 3'h4);
			cfg = {hdr, i[2], i[1], (hdr == 3'h5) ? 2'h0 : seed[31:30], i[0]};
			if (hdr == 3'h5) cur = 3'(i);
			wait_idle();
			mst.start();
			wb({addr_tab[8], 1'b0}, 1'b0);
			wb(cfg, 1'b0);
			mst.start();
			wb({addr_tab[8], 1'b1}, 1'b0);
			for (int b = 0; b < 3; b++) begin
				mst.xbyte(8'hFF, i == 15, q, a);
				rd = {rd[15:0], q};
				if (i == 15) break;
			end
			ew = exp_word(sample);
			if (i == 15) begin
				chk({16'h0, rd[7:0]}, {16'h0, ew[23:16]});
			end else begin
				chk(rd, ew);
				chk({23'h0, busy}, 24'h1);
			end
			mst.stop();
			tick(6);
			chk({12'h0, busy, single_ended_sel, pos, neg}, {12'h0, 1'b1, exp_route(cur)});
		end
		$display("Conversion read tests done");
		results();
	end
endmodule
